// ### bench/pme_engine_asserts.sv
// Port-level checker of the motion engine control block.
// Assumes it is bound into pme_engine and sees only that module's ports.
`timescale 1ns/1ns
module pme_engine_asserts
  import pme_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic adc_done_i,
  input wire logic engine_disabled_o,
  input wire logic motion_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic acc;
  logic clr_motion;
  logic mask_wr;
  assign acc = psel_i && penable_i;
  assign clr_motion = acc && pwrite_i && paddr_i == 12'h408 && !pwdata_i[1];
  assign mask_wr = acc && pwrite_i && paddr_i == 12'h444;
  // Four cycles off covers the conversion that was in flight at the disable
  sequence s_off_run;
    engine_disabled_o [*4];
  endsequence
  sequence s_conv_seen;
    $past(adc_done_i, 2) || $past(adc_done_i, 3);
  endsequence
  chk_motion_cause: assert property ($rose(motion_o) |-> s_conv_seen) else $error("motion set without conversion");
  chk_motion_held: assert property (motion_o && !clr_motion |=> motion_o) else $error("motion dropped");
  chk_motion_clear: assert property ($fell(motion_o) |-> $past(clr_motion)) else $error("motion cleared by engine");
  chk_off_rise: assert property ($rose(engine_disabled_o) |-> $past(adc_done_i)) else $error("disable off conversion");
  chk_on_fall: assert property ($fell(engine_disabled_o) |-> $past(adc_done_i)) else $error("enable off conversion");
  chk_off_quiet: assert property (s_off_run ##0 !motion_o |=> !motion_o) else $error("motion while off");
  chk_irq_cause: assert property ($rose(irq_o) |-> (($past(adc_done_i) || $past(mask_wr)) or s_conv_seen))
    else $error("irq without event");
  chk_err_misalign: assert property (acc && paddr_i[1:0] != 2'h0 |-> pslverr_o) else $error("misaligned accepted");
  chk_ok_mapped: assert property (acc && paddr_i == 12'h408 |-> pready_o && !pslverr_o) else $error("mapped refused");
  chk_err_idle: assert property (!acc |-> !pslverr_o) else $error("error outside access");
endmodule : pme_engine_asserts

bind pme_engine pme_engine_asserts u_chk (.*);

// ### bench/pme_engine_tb_top.sv
// Self-checking bench of the motion engine control block.
// Assumes pme_engine with a zero-wait APB slave and SETTLE_TICKS of one.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module pme_engine_tb_top;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic err;
  } pme_row_t;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic adc = 1'b0;
  logic [9:0] smp = 10'h0c8;
  logic wake = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic dis;
  logic mot;
  logic irq;
  logic [31:0] rdv;
  logic erv;
  int fails = 0;
  int check_count = 0;
  pme_row_t rows [18] = '{
    '{1'b0, 12'h400, 8'h00, 8'h00, 1'b0},
    '{1'b0, 12'h404, 8'h00, 8'h10, 1'b0},
    '{1'b0, 12'h408, 8'h00, 8'h20, 1'b0},
    '{1'b0, 12'h40c, 8'h00, 8'h60, 1'b0},
    '{1'b0, 12'h444, 8'h00, 8'h00, 1'b0},
    '{1'b0, 12'h440, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h404, 8'hff, 8'h00, 1'b0},
    '{1'b0, 12'h404, 8'h00, 8'hff, 1'b0},
    '{1'b1, 12'h408, 8'hff, 8'h00, 1'b0},
    '{1'b0, 12'h408, 8'h00, 8'hf8, 1'b0},
    '{1'b1, 12'h40c, 8'hff, 8'h00, 1'b0},
    '{1'b0, 12'h40c, 8'h00, 8'he7, 1'b0},
    '{1'b1, 12'h40c, 8'h60, 8'h00, 1'b0},
    '{1'b0, 12'h40c, 8'h00, 8'h60, 1'b0},
    '{1'b0, 12'h460, 8'h00, 8'h00, 1'b1},
    '{1'b1, 12'h401, 8'h11, 8'h00, 1'b1},
    '{1'b1, 12'h444, 8'h0f, 8'h00, 1'b0},
    '{1'b0, 12'h444, 8'h00, 8'h0f, 1'b0}
  };
  always #10 clock_i = ~clock_i;
  pme_engine #(.SAMPLE_W(10), .SETTLE_TICKS(1)) DUT (
    .clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .adc_done_i(adc), .sample_i(smp), .wake_i(wake), .engine_disabled_o(dis), .motion_o(mot), .irq_o(irq)
  );
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // An idle edge before each setup keeps the select from being rewritten in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock_i);
    pen <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1) @(posedge clock_i);
    rdv = prdata;
    erv = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK($sformatf("read %h", a), {24'h0, e}, rdv)
  endtask : rd
  task automatic conv(input logic [9:0] v);
    @(posedge clock_i);
    adc <= 1'b1;
    smp <= v;
    @(posedge clock_i);
    adc <= 1'b0;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
  endtask : conv
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) `CHK("row read", {24'h0, rows[i].e}, rdv)
      `CHK("row error", rows[i].err, erv)
    end
    apb(1'b1, 12'h400, 8'h5a);
    conv(10'h0c8);
    `CHK("disabled", 1'b1, dis)
    apb(1'b1, 12'h400, 8'h11);
    conv(10'h0c8);
    `CHK("disabled", 1'b0, dis)
    rd(12'h440, 8'h04);
    @(negedge clock_i);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, 12'h408, 8'h08);
    apb(1'b1, 12'h444, 8'h00);
    // First sample after enable only primes the baseline, so it cannot count as quiet
    conv(10'h0c8);
    apb(1'b1, 12'h40c, 8'he0);
    rd(12'h40c, 8'he0);
    conv(10'h0c8);
    rd(12'h40c, 8'h60);
    rd(12'h408, 8'h09);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, 12'h444, 8'h0f);
    @(negedge clock_i);
    `CHK("irq", 1'b1, irq)
    rd(12'h440, 8'h0a);
    apb(1'b1, 12'h404, 8'h04);
    conv(10'h12c);
    `CHK("motion", 1'b1, mot)
    rd(12'h408, 8'h0f);
    conv(10'h064);
    rd(12'h408, 8'h0f);
    apb(1'b1, 12'h408, 8'h0a);
    @(negedge clock_i);
    `CHK("motion", 1'b1, mot)
    apb(1'b1, 12'h408, 8'h10);
    @(negedge clock_i);
    `CHK("motion", 1'b0, mot)
    conv(10'h190);
    `CHK("motion", 1'b0, mot)
    apb(1'b1, 12'h408, 8'h00);
    @(negedge clock_i);
    `CHK("motion", 1'b0, mot)
    conv(10'h190);
    `CHK("motion", 1'b1, mot)
    // Return from sleep drops the settled flag; direction stays with the flag
    @(posedge clock_i);
    wake <= 1'b1;
    @(posedge clock_i);
    wake <= 1'b0;
    rd(12'h408, 8'h06);
    apb(1'b1, 12'h400, 8'h00);
    @(negedge clock_i);
    `CHK("disabled", 1'b0, dis)
    conv(10'h0c8);
    `CHK("disabled", 1'b1, dis)
    apb(1'b1, 12'h408, 8'h00);
    conv(10'h3ff);
    `CHK("motion", 1'b0, mot)
    apb(1'b1, 12'h400, 8'h11);
    conv(10'h0c8);
    apb(1'b0, 12'h408, 8'h00);
    `CHK("settled", 1'b0, rdv[0])
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    `CHK("disabled", 1'b1, dis)
    `CHK("irq", 1'b0, irq)
    rd(12'h408, 8'h20);
    rd(12'h404, 8'h10);
    report_and_stop();
  end
endmodule : pme_engine_tb_top

// ### common/pme_pkg.sv
// Constants and carrier types of the motion engine control block.
// Assumes a 32-bit APB slave port and a word-aligned register map.
package pme_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // Register indices; byte address is index times four
  localparam logic [IDX_W-1:0] IDX_ENABLE = 10'h100;
  localparam logic [IDX_W-1:0] IDX_SENS = 10'h101;
  localparam logic [IDX_W-1:0] IDX_SC0 = 10'h102;
  localparam logic [IDX_W-1:0] IDX_SC1 = 10'h103;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h110;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h111;
  localparam logic [7:0] ENGINE_ENABLE_CODE = 8'h11;
  localparam logic [7:0] ENGINE_DISABLE_CODE = 8'h00;
  // motion_status_mode_control fields
  localparam int SC0_EXT_LSB = 6;
  localparam int SC0_DISABLED = 5;
  localparam int SC0_SUSPEND = 4;
  localparam int SC0_DIRCTL = 3;
  localparam int SC0_DIR = 2;
  localparam int SC0_MOTION = 1;
  localparam int SC0_SETTLED = 0;
  // engine_status_control fields
  localparam int SC1_TICK = 7;
  localparam int SC1_FR_LSB = 3;
  localparam int SC1_OPT_LSB = 0;
  localparam logic [3:0] FR_MAX = 4'hc;
  // Interrupt status bits
  localparam int IRQ_MOTION = 0;
  localparam int IRQ_SETTLED = 1;
  localparam int IRQ_ENGINE = 2;
  localparam int IRQ_TICK = 3;
  localparam int IRQ_W = 4;
  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SENS = 8'h10;
  localparam logic [1:0] RST_EXT = 2'h0;
  localparam logic [3:0] RST_FR = 4'hc;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 4'h0;
  localparam logic [5:0] RST_SETTLE_CNT = 6'h00;
  // Sample deviation still counted as a quiet, settled offset
  localparam int QUIET_LIMIT = 4;
  localparam int SETTLE_SECONDS = 4;

  typedef struct packed {
    logic [7:0] sens;
    logic [1:0] ext;
    logic [3:0] freq_resp;
  } pme_det_cfg_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic positive;
    logic quiet;
  } pme_det_res_t;

  typedef struct packed {
    logic [7:0] enable_code;
    logic [7:0] sens;
    logic [1:0] ext;
    logic disabled;
    logic suspend;
    logic dirctl;
    logic dir;
    logic motion;
    logic settled;
    logic tick;
    logic [3:0] freq_resp;
    logic [2:0] sc1_opt;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic suspended;
    logic [5:0] settle_cnt;
    logic [31:0] rdata;
  } pme_state_t;
endpackage : pme_pkg

// ### logic/pme_detector.sv
// Baseline tracker and threshold detector of the motion engine.
// Assumes one sample per conversion strobe, all on clock_i.
`timescale 1ns/1ns
module pme_detector
  import pme_pkg::*;
#(
  parameter int SAMPLE_W = 10
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic sample_valid_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire pme_det_cfg_t cfg_i,
  output pme_det_res_t res_o
);
  typedef struct packed {
    logic [SAMPLE_W-1:0] baseline;
    logic primed;
    pme_det_res_t res;
  } pme_det_state_t;

  pme_det_state_t st;
  pme_det_state_t next_st;
  logic signed [SAMPLE_W:0] dev;
  logic signed [SAMPLE_W:0] step;
  logic [SAMPLE_W:0] mag;
  logic [SAMPLE_W:0] thr;
  logic [2:0] shift;

  always_comb begin
    next_st = st;
    next_st.res.valid = 1'b0;
    dev = $signed({1'b0, sample_i}) - $signed({1'b0, st.baseline});
    mag = dev[SAMPLE_W] ? (SAMPLE_W+1)'(-dev) : dev;
    // Higher extended level lowers the threshold further
    thr = (SAMPLE_W+1)'(cfg_i.sens >> cfg_i.ext); // [R1] [R2]
    // Slower baseline for higher values lets low frequencies through
    shift = 3'(cfg_i.freq_resp[3:2]) + 3'h1; // [R12]
    step = dev >>> shift;
    if (run_i && sample_valid_i) begin
      next_st.res.valid = 1'b1;
      next_st.res.hit = st.primed && (mag > thr);
      next_st.res.positive = ~dev[SAMPLE_W];
      next_st.res.quiet = st.primed && (mag <= (SAMPLE_W+1)'(QUIET_LIMIT));
      if (!st.primed) begin
        next_st.baseline = sample_i;
        next_st.primed = 1'b1;
      end else begin
        next_st.baseline = SAMPLE_W'($signed({1'b0, st.baseline}) + step);
      end
    end else if (!run_i) begin
      next_st.primed = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign res_o = st.res;
endmodule : pme_detector

// ### logic/pme_engine.sv
// What this block does
// [R1] Sensitivity code is an inverse threshold; low codes sense more.
// [R2] Two-bit extended level 0..3 raises sensitivity further.
// [R3] Enable code clears disabled flag; disable code sets it, engine idles.
// [R4] Software lets one conversion pass after writing the disable code.
// [R5] Suspend stops detection but samples keep being buffered.
// [R6] Clearing suspend takes effect at the next conversion.
// [R7] Direction reported only in directional mode; detection always.
// [R8] Direction written with motion flag and held until flag cleared.
// [R9] Engine sets motion flag, never clears it; software clears it.
// [R10] Settled flag set when offset stays quiet; cleared on restart/wake.
// [R11] Software sets tick each second; engine consumes and clears it.
// [R12] Frequency response limited to 0..12; higher admits lower frequency.
// [R13] Software calibrates direction polarity per sensor.
// [R14] Only the enable code enables, disable code stops, others reserved.
// [R15] Writes to engine-owned read-only fields are ignored.
//
// Register slave on APB, zero wait states; engine is paced by the
// conversion strobe adc_done_i, which comes from logic on clock_i.
`timescale 1ns/1ns
module pme_engine
  import pme_pkg::*;
#(
  parameter int SAMPLE_W = 10,
  parameter int SETTLE_TICKS = SETTLE_SECONDS
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic adc_done_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic wake_i,
  output logic engine_disabled_o,
  output logic motion_o,
  output logic irq_o
);
  pme_state_t st;
  pme_state_t next_st;
  pme_det_cfg_t det_cfg;
  pme_det_res_t det_res;
  logic access;
  logic setup;
  logic [IDX_W-1:0] idx;
  logic mapped;
  logic wr;
  logic rd;
  logic tick_set;
  logic [IRQ_W-1:0] ev;
  logic [3:0] fr_in;
  logic detecting;
  logic [7:0] sc0_word;
  logic [7:0] sc1_word;

  // Baseline keeps running while suspended so recovery is fast
  assign det_cfg = '{sens: st.sens, ext: st.ext, freq_resp: st.freq_resp};

  pme_detector #(
    .SAMPLE_W(SAMPLE_W)
  ) u_det (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .run_i(~st.disabled),
    .sample_valid_i(adc_done_i),
    .sample_i(sample_i),
    .cfg_i(det_cfg),
    .res_o(det_res)
  );

  always_comb begin
    sc0_word = {st.ext, st.disabled, st.suspend, st.dirctl, st.dir,
                st.motion, st.settled};
    sc1_word = {st.tick, st.freq_resp, st.sc1_opt};
  end

  always_comb begin
    access = psel_i && penable_i;
    setup = psel_i && !penable_i;
    idx = paddr_i[ADDR_W-1:2];
    mapped = (paddr_i[1:0] == 2'h0) &&
             (idx == IDX_ENABLE || idx == IDX_SENS ||
              idx == IDX_SC0 || idx == IDX_SC1 ||
              idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);
    wr = access && pwrite_i && mapped;
    rd = access && !pwrite_i && mapped;
  end

  always_comb begin
    next_st = st;
    tick_set = 1'b0;
    ev = '0;
    fr_in = pwdata_i[SC1_FR_LSB+3:SC1_FR_LSB];

    // Read data is captured in the setup cycle so it comes from a flop
    if (setup) begin
      next_st.rdata = 32'h0;
      unique case (idx)
        IDX_ENABLE: next_st.rdata = {24'h0, st.enable_code};
        IDX_SENS: next_st.rdata = {24'h0, st.sens};
        IDX_SC0: next_st.rdata = {24'h0, sc0_word};
        IDX_SC1: next_st.rdata = {24'h0, sc1_word};
        IDX_IRQ_STAT: next_st.rdata = {28'h0, st.irq_stat};
        IDX_IRQ_MASK: next_st.rdata = {28'h0, st.irq_mask};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // Reading the status word clears it; events below still win
    if (rd && idx == IDX_IRQ_STAT) begin
      next_st.irq_stat = '0;
    end

    if (wr) begin
      unique case (idx)
        IDX_ENABLE: begin
          next_st.enable_code = pwdata_i[7:0];
        end
        IDX_SENS: begin
          next_st.sens = pwdata_i[7:0];
        end
        IDX_SC0: begin
          // Disabled, direction and settled bits are engine-owned
          next_st.ext = pwdata_i[SC0_EXT_LSB+1:SC0_EXT_LSB]; // [R15]
          next_st.suspend = pwdata_i[SC0_SUSPEND];
          next_st.dirctl = pwdata_i[SC0_DIRCTL];
          if (!pwdata_i[SC0_MOTION]) begin
            next_st.motion = 1'b0; // [R9]
          end
        end
        IDX_SC1: begin
          tick_set = pwdata_i[SC1_TICK];
          next_st.tick = pwdata_i[SC1_TICK];
          // Out-of-range response codes saturate at the top value
          next_st.freq_resp = (fr_in > FR_MAX) ? FR_MAX : fr_in; // [R12]
          next_st.sc1_opt = pwdata_i[SC1_OPT_LSB+2:SC1_OPT_LSB];
        end
        IDX_IRQ_MASK: begin
          next_st.irq_mask = pwdata_i[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Engine service: runs at the conversion strobe and again when its detector result is valid
    if (det_res.valid || adc_done_i) begin
      if (st.enable_code == ENGINE_DISABLE_CODE) begin
        if (!st.disabled) begin
          next_st.disabled = 1'b1; // [R3] [R14]
          ev[IRQ_ENGINE] = 1'b1;
        end
      end else if (st.enable_code == ENGINE_ENABLE_CODE &&
                   st.disabled) begin
        // Re-enable loads the engine-owned defaults
        next_st.disabled = 1'b0; // [R3] [R14]
        // Only software clears the motion flag, and direction stays with it
        if (!st.motion) begin
          next_st.dir = 1'b0; // [R8] [R9]
        end
        next_st.settled = 1'b0; // [R10]
        next_st.settle_cnt = RST_SETTLE_CNT;
        next_st.suspended = st.suspend;
        ev[IRQ_ENGINE] = 1'b1;
      end
    end

    // Suspend state follows the control bit only at a conversion
    if (adc_done_i && !st.disabled) begin
      next_st.suspended = st.suspend; // [R5] [R6]
    end

    if (det_res.valid && !st.disabled &&
        st.enable_code != ENGINE_DISABLE_CODE) begin
      if (st.tick) begin
        // A fresh tick written in this cycle is kept
        next_st.tick = tick_set; // [R11]
        ev[IRQ_TICK] = 1'b1;
        if (!det_res.quiet) begin
          next_st.settle_cnt = RST_SETTLE_CNT; // [R10]
        end else if (!st.settled) begin
          next_st.settle_cnt = st.settle_cnt + 6'h01;
          if (st.settle_cnt + 6'h01 >= 6'(SETTLE_TICKS)) begin
            next_st.settled = 1'b1; // [R10]
            ev[IRQ_SETTLED] = 1'b1;
          end
        end
      end

      if (detecting && det_res.hit) begin
        // Direction only latched while the flag goes from clear to set
        if (!next_st.motion && st.dirctl) begin
          next_st.dir = det_res.positive; // [R7] [R8]
        end
        next_st.motion = 1'b1; // [R9]
        ev[IRQ_MOTION] = 1'b1;
      end
    end

    // Return from sleep restarts offset settling
    if (wake_i) begin
      next_st.settled = 1'b0; // [R10]
      next_st.settle_cnt = RST_SETTLE_CNT;
    end

    next_st.irq_stat = next_st.irq_stat | ev;
  end

  // Motion hits while unsettled are invalid, so they are not reported
  assign detecting = !st.suspend && !st.suspended && st.settled; // [R5] [R10]

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.enable_code <= RST_ENABLE;
      st.sens <= RST_SENS;
      st.ext <= RST_EXT;
      st.disabled <= 1'b1;
      st.freq_resp <= RST_FR;
      st.irq_mask <= RST_IRQ_MASK;
      st.settle_cnt <= RST_SETTLE_CNT;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o = st.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = access && !mapped;
  assign engine_disabled_o = st.disabled;
  assign motion_o = st.motion;
  assign irq_o = |(st.irq_stat & st.irq_mask);
endmodule : pme_engine
